// ==== bench/hac_config_regs_properties.sv ====
// assertion checker bound to the configuration register block
`timescale 1ns/10ps
`default_nettype none

module hac_config_regs_checker #(
   parameter int unsigned TIMEOUT_CYCLES = 200
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_n,
   input wire logic accel_en,
   input wire logic [7:0] wave_level,
   input wire logic [7:0] overdrive_req,
   input wire logic [14:0] resonant_period_value,
   input wire logic [7:0] drive_full_scale,
   input wire logic [7:0] drive_level,
   input wire logic [7:0] overdrive_level,
   input wire logic [4:0] drive_current_rating,
   input wire logic link_busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // two idle cycles with an unchanged acceleration choice, outside the reset release edge
   sequence quiet_s;
      rst_n && !link_busy ##1 !link_busy && $stable(accel_en);
   endsequence

   reset_vals_a:
   assert property (disable iff (1'b0) !rst_n |=> resonant_period_value == 15'h10cf && drive_current_rating == 5'h17
      && drive_full_scale == 8'h5a && drive_level == 8'h00 && overdrive_level == 8'h00 && !link_busy)
      else $error("outputs not at reset values");
   od_pass_a:
   assert property (rst_n && !accel_en |=> overdrive_level == $past(overdrive_req)) else $error("overdrive altered");
   od_clamp_a:
   assert property (rst_n && accel_en |=> overdrive_level <= $past(overdrive_req)) else $error("overdrive raised");
   drive_scale_a:
   assert property (rst_n |=> 16'(drive_level) == 16'(16'($past(wave_level)) * 16'(drive_full_scale) / 16'd255))
      else $error("drive level not scaled");
   sda_release_a:
   assert property (!link_busy [*4] |-> sda_oe_n) else $error("wire held outside a frame");
   open_drain_a:
   assert property (sda_o == 1'b0) else $error("data output not low");
   cfg_hold_a:
   assert property ($past(rst_n) && !link_busy && !$past(link_busy) |-> $stable({resonant_period_value,
      drive_current_rating})) else $error("setting changed without a frame");
   fs_hold_a:
   assert property (quiet_s |=> $stable(drive_full_scale)) else $error("full scale changed");
endmodule

bind hac_config_regs hac_config_regs_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) hac_config_regs_checker_i (
   .clk, .rst_n, .scl, .sda_i, .sda_o, .sda_oe_n, .accel_en, .wave_level, .overdrive_req,
   .resonant_period_value, .drive_full_scale, .drive_level, .overdrive_level, .drive_current_rating, .link_busy);

`default_nettype wire

// ==== bench/hac_config_regs_tb_top.sv ====
// self-checking bench of the configuration register block over its serial link
`timescale 1ns/10ps
`default_nettype none

module hac_config_regs_tb_top;
   // shortened bus idle timeout so the run stays short
   localparam int TO_CYC = 200;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic accel_en = 1'b1;
   logic [7:0] wave_level = 8'h00;
   logic [7:0] overdrive_req = 8'h00;
   logic scl, host_sda_n, sda_o, sda_oe_n, link_busy;
   logic [14:0] resonant_period_value;
   logic [7:0] drive_full_scale, drive_level, overdrive_level;
   logic [4:0] drive_current_rating;
   wire logic sda_w;
   int failures = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [7:0] rx;
   logic ack;

   // pull-up: the wire is low when either party pulls it
   assign sda_w = host_sda_n & sda_oe_n;

   always #10 clk = ~clk;

   hac_config_regs #(.TIMEOUT_CYCLES(TO_CYC)) hac_config_regs_i (.clk, .rst_n, .scl, .sda_i(sda_w), .sda_o,
      .sda_oe_n, .accel_en, .wave_level, .overdrive_req, .resonant_period_value, .drive_full_scale,
      .drive_level, .overdrive_level, .drive_current_rating, .link_busy);
   hac_host_model hac_host_model_i (.scl, .sda_pull_n(host_sda_n), .sda(sda_w));

   // verdict and end of run
   task automatic stop_test();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // value comparison, case equality so unknowns fail
   task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // one written byte, which the device must acknowledge
   task automatic send(input logic [7:0] b);
      logic [7:0] r;
      logic a;
      hac_host_model_i.byte_x(b, 1'b1, r, a);
      cmp("ack", 16'h1, {15'h0, a});
   endtask

   // write frame: device address then the given byte list
   task automatic wr_seq(input logic [7:0] q[$]);
      hac_host_model_i.start();
      send(8'h94);
      foreach (q[i]) send(q[i]);
      hac_host_model_i.stop();
   endtask

   // pointer set, repeated start, one byte read with a closing nack
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic k;
      hac_host_model_i.start();
      send(8'h94);
      send(a);
      hac_host_model_i.start();
      send(8'h95);
      hac_host_model_i.byte_x(8'hff, 1'b1, r, k);
      hac_host_model_i.stop();
      cmp($sformatf("reg %h", a), {8'h0, exp}, {8'h0, r});
   endtask

   // read the whole mapped set in offset order
   task automatic rd_all(input logic [7:0] e[6]);
      logic [7:0] ofs[6] = '{8'h08, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e};
      foreach (ofs[i]) rd_chk(ofs[i], e[i]);
   endtask

   // apply drive inputs and check the registered drive outputs
   task automatic drv(input logic acc, input logic [7:0] w, input logic [7:0] od, input logic [7:0] fs,
                      input logic [7:0] eod);
      @(posedge clk);
      accel_en <= acc;
      wave_level <= w;
      overdrive_req <= od;
      repeat (3) @(posedge clk);
      #1;
      cmp("full scale", {8'h0, fs}, {8'h0, drive_full_scale});
      cmp("drive level", 16'(w) * 16'(fs) / 16'd255, {8'h0, drive_level});
      cmp("overdrive", {8'h0, eod}, {8'h0, overdrive_level});
   endtask

   // hang guard well above the expected run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmp("period", 16'h10cf, {1'b0, resonant_period_value});
      cmp("current", 16'h17, {11'h0, drive_current_rating});
      rd_all('{8'h40, 8'h21, 8'h4f, 8'h5a, 8'h78, 8'h17});
      // a foreign device address gets no acknowledge
      hac_host_model_i.start();
      hac_host_model_i.byte_x(8'h96, 1'b1, rx, ack);
      hac_host_model_i.stop();
      cmp("foreign ack", 16'h0, {15'h0, ack});
      wr_seq('{8'h0a, 8'hff, 8'hff, 8'h12, 8'h34, 8'hff});
      rd_all('{8'h40, 8'hff, 8'h7f, 8'h12, 8'h34, 8'h1f});
      cmp("period", 16'h7fff, {1'b0, resonant_period_value});
      cmp("current", 16'h1f, {11'h0, drive_current_rating});
      // unmapped offsets ignore writes and read zero
      wr_seq('{8'h09, 8'haa});
      rd_chk(8'h09, 8'h00);
      rd_chk(8'h0f, 8'h00);
      wr_seq('{8'h08, 8'hff});
      rd_chk(8'h08, 8'hc0);
      wr_seq('{8'h0c, 8'h20, 8'h0b, 8'h05, 8'h08, 8'h40});
      rd_all('{8'h40, 8'hff, 8'h05, 8'h20, 8'h34, 8'h1f});
      cmp("period", 16'h7f85, {1'b0, resonant_period_value});
      // burst read: an acked byte moves the pointer on
      wr_seq('{8'h0d});
      hac_host_model_i.start();
      send(8'h95);
      hac_host_model_i.byte_x(8'hff, 1'b0, rx, ack);
      cmp("burst 0d", 16'h34, {8'h0, rx});
      hac_host_model_i.byte_x(8'hff, 1'b1, rx, ack);
      cmp("burst 0e", 16'h1f, {8'h0, rx});
      hac_host_model_i.stop();
      drv(1'b1, 8'hff, 8'hff, 8'h20, 8'h34);
      drv(1'b1, 8'h80, 8'h10, 8'h20, 8'h10);
      drv(1'b0, 8'h80, 8'hff, 8'h34, 8'hff);
      // timeout disabled: a stalled frame stays open
      wr_seq('{8'h08, 8'h00});
      hac_host_model_i.start();
      repeat (TO_CYC + 40) @(posedge clk);
      cmp("busy", 16'h1, {15'h0, link_busy});
      hac_host_model_i.stop();
      // timeout enabled: the stalled frame is dropped near the limit
      wr_seq('{8'h08, 8'h40});
      hac_host_model_i.start();
      repeat (TO_CYC - 20) @(posedge clk);
      cmp("busy", 16'h1, {15'h0, link_busy});
      repeat (40) @(posedge clk);
      cmp("busy", 16'h0, {15'h0, link_busy});
      hac_host_model_i.stop();
      rd_chk(8'h0d, 8'h34);
      // second reset in mid-run restores every setting
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_all('{8'h40, 8'h21, 8'h4f, 8'h5a, 8'h78, 8'h17});
      stop_test();
   end
endmodule

`default_nettype wire

// ==== bench/hac_host_model.sv ====
// behavioural serial host that clocks the link and moves bytes on the open-drain data wire
`timescale 1ns/10ps
`default_nettype none

module hac_host_model (
   output logic scl,
   output logic sda_pull_n,
   input wire logic sda
);
   // half period off the 20 ns grid so link edges drift against the system clock
   localparam int H = 205;

   // link clock stands high and the wire is released between frames
   initial begin
      scl = 1'b1;
      sda_pull_n = 1'b1;
   end

   // start or repeated start: data falls while the clock is high
   task automatic start();
      #(H / 2);
      sda_pull_n = 1'b1;
      #(H / 2);
      scl = 1'b1;
      #H;
      sda_pull_n = 1'b0;
      #H;
      scl = 1'b0;
   endtask

   // stop: data rises while the clock is high, then idle
   task automatic stop();
      #(H / 2);
      sda_pull_n = 1'b0;
      #(H / 2);
      scl = 1'b1;
      #H;
      sda_pull_n = 1'b1;
      #H;
   endtask

   // one bit slot: data set in the low phase, sampled mid high phase
   task automatic bit_x(input logic b, output logic s);
      #(H / 2);
      sda_pull_n = b;
      #(H / 2);
      scl = 1'b1;
      #(H / 2);
      s = sda;
      #(H / 2);
      scl = 1'b0;
   endtask

   // byte slot, msb first, ninth bit carries the acknowledge
   task automatic byte_x(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(tx[i], rx[i]);
      end
      bit_x(mack, s);
      ack = ~s;
   endtask
endmodule

`default_nettype wire

// ==== rtl/hac_config_regs.sv ====
// configuration register bank of the haptic actuator driver with its serial link slave
//
// Notes on behaviour
// R1: mode 0: one address, data auto-increments
// R2: mode 1: address before every data byte
// R3: timeout resets slave after 35 ms idle
// R4: period value is high*128 plus low
// R5: period counted in 1333.32 ns units
// R6: nominal voltage is full scale with acceleration
// R7: acceleration clamps overdrive to absolute maximum
// R8: absolute maximum is full scale without acceleration
// R9: five-bit current rating field, reset 0x17
// R10: acceleration enable selects full-scale setting
// R11: unused bits ignore writes, read zero
`timescale 1ns/10ps
`default_nettype none

module hac_config_regs
   import hac_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES,
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic accel_en,
   input wire logic [7:0] wave_level,
   input wire logic [7:0] overdrive_req,
   output logic [14:0] resonant_period_value,
   output logic [7:0] drive_full_scale,
   output logic [7:0] drive_level,
   output logic [7:0] overdrive_level,
   output logic [4:0] drive_current_rating,
   output logic link_busy
);

   localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

   // pin synchronisers
   logic scl_s1_q;           // first stage, read only by the second
   logic scl_s2_q;           // synchronised link clock level
   logic sda_s1_q;           // first stage, read only by the second
   logic sda_s2_q;           // synchronised data line level
   logic scl_p_q;            // previous synchronised clock level
   logic sda_p_q;            // previous synchronised data level

   // frame tracking
   logic start_det;          // data falls while clock high
   logic stop_det;           // data rises while clock high
   logic scl_fall;           // falling edge of the link clock
   logic start_p_q;          // start seen one cycle ago
   logic busy_q;             // a frame is in progress
   logic link_rst_n_q;       // reset of the link domain, low between frames
   logic [2:0] rst_hist_q;   // recent history of the link reset
   logic [TO_W-1:0] to_cnt_q; // cycles since the last falling link edge
   logic timeout;            // idle limit reached with the timeout enabled

   // event crossing
   hac_evt_t link_evt;       // event word held by the link domain
   logic link_tgl;           // event toggle from the link domain
   logic tgl_s1_q;           // first stage, read only by the second
   logic tgl_s2_q;           // synchronised toggle
   logic tgl_last_q;         // toggle value already handled
   logic evt_fire;           // one-cycle pulse per link event
   logic wr_fire;            // data byte to be written at the pointer

   // register file
   logic [7:0] ptr_q;        // register pointer
   logic [7:0] link_ctrl_q;  // host_link_control, only the defined bits
   logic [7:0] per_hi_q;     // resonant_period_high_part
   logic [6:0] per_lo_q;     // resonant_period_low_part
   logic [7:0] nom_q;        // nominal voltage setting
   logic [7:0] abs_q;        // absolute maximum voltage setting
   logic [4:0] cur_q;        // drive_current_rating
   logic [7:0] rd_byte_q;    // read data for the current pointer
   logic wr_mode;            // 1: repeat mode, 0: auto-increment
   logic to_en;              // bus_idle_timeout_enable

   // read decode, used for the link and kept as one place of truth
   function automatic logic [7:0] rd_mux(input logic [7:0] addr, input logic [7:0] ctrl,
                                         input logic [7:0] hi, input logic [6:0] lo,
                                         input logic [7:0] nom, input logic [7:0] abs_v,
                                         input logic [4:0] cur);
      logic [7:0] r;
      r = 8'h00;
      unique case (addr)
         HOST_LINK_CONTROL_OFS: r = ctrl & HOST_LINK_CONTROL_MASK;
         RESONANT_PERIOD_HIGH_OFS: r = hi;
         RESONANT_PERIOD_LOW_OFS: r = {1'b0, lo};
         NOMINAL_VOLTAGE_SETTING_OFS: r = nom;
         ABSOLUTE_VOLTAGE_SETTING_OFS: r = abs_v;
         CURRENT_RATING_SETTING_OFS: r = {3'h0, cur};
         // unmapped offsets read as zero
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // scale an unsigned waveform sample so that 0xff maps exactly to full scale
   function automatic logic [7:0] scale(input logic [7:0] w, input logic [7:0] fs);
      logic [15:0] prod;
      logic [15:0] quot;
      prod = {8'h00, w} * {8'h00, fs};
      quot = prod / 16'h00ff;
      return quot[7:0];
   endfunction

   // lesser of two unsigned codes
   function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
      return (a < b) ? a : b;
   endfunction

   // link slave on its own clock
   hac_i2c_link #(
      .DEV_ADDR(DEV_ADDR)
   ) u_link (
      .scl(scl),
      .link_rst_n(link_rst_n_q),
      .sda_i(sda_i),
      .wr_mode_async(wr_mode),
      .rd_byte(rd_byte_q),
      .sda_oe_n(sda_oe_n),
      .evt_q(link_evt),
      .evt_tgl_q(link_tgl)
   );

   // the slave only ever pulls the open-drain line low
   assign sda_o = 1'b0;

   // control fields of host_link_control
   assign wr_mode = link_ctrl_q[WR_MODE_BIT];
   assign to_en = link_ctrl_q[BUS_IDLE_TIMEOUT_ENABLE_BIT];

   // two-stage synchronisers for the raw pins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else begin
         scl_s1_q <= scl;
         scl_s2_q <= scl_s1_q;
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
      end
   end

   // previous levels for edge detection, taken only from the second stages
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_s2_q;
         sda_p_q <= sda_s2_q;
      end
   end

   // start and stop are the only data changes allowed while the clock is high
   assign start_det = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
   assign stop_det = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
   assign scl_fall = scl_p_q & ~scl_s2_q;

   // R3: idle counter, cleared by each falling edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         to_cnt_q <= '0;
      end else if (!busy_q || scl_fall) begin
         to_cnt_q <= '0;
      end else if (to_cnt_q != TO_LAST) begin
         to_cnt_q <= to_cnt_q + TO_W'(1);
      end
   end

   // R3: limit reached only when enabled
   assign timeout = busy_q & to_en & (to_cnt_q == TO_LAST);

   // frame state; a timeout ends the frame like a stop would
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         start_p_q <= 1'b0;
      end else begin
         start_p_q <= start_det;
         if (start_det) begin
            busy_q <= 1'b1;
         end else if (stop_det || timeout) begin
            busy_q <= 1'b0;
         end
      end
   end

   // R3: link logic held in reset outside frames and on timeout
   // a repeated start also pulses it, so every frame begins from the address byte;
   // the pulse is at least two cycles so the link toggle settles before events count
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_rst_n_q <= 1'b0;
         rst_hist_q <= 3'h0;
      end else begin
         link_rst_n_q <= busy_q & ~start_det & ~start_p_q & ~timeout;
         rst_hist_q <= {rst_hist_q[1:0], link_rst_n_q};
      end
   end

   // event toggle synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tgl_s1_q <= 1'b0;
         tgl_s2_q <= 1'b0;
         tgl_last_q <= 1'b0;
      end else begin
         tgl_s1_q <= link_tgl;
         tgl_s2_q <= tgl_s1_q;
         tgl_last_q <= tgl_s2_q;
      end
   end

   // a toggle that comes from the link reset itself is not an event; the event word
   // stays stable for a whole byte slot, so it is safe to read when the toggle lands
   assign evt_fire = (tgl_s2_q != tgl_last_q) & (&rst_hist_q) & link_rst_n_q;
   assign wr_fire = evt_fire & (link_evt.kind == EV_DATA);

   // pointer: set by an address byte, advanced by data bytes in auto-increment mode and by read bytes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_q <= 8'h00;
      end else if (evt_fire) begin
         unique case (link_evt.kind)
            // R1: the address byte loads the pointer
            EV_ADDR: ptr_q <= link_evt.data;
            // R1 R2: step only in auto-increment mode
            EV_DATA: begin
               if (!wr_mode) begin
                  ptr_q <= ptr_q + 8'h01;
               end
            end
            // reads always move on to the next register
            EV_NEXT: ptr_q <= ptr_q + 8'h01;
            // undefined kind code
            default: ptr_q <= ptr_q;
         endcase
      end
   end

   // register writes at the pointer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         link_ctrl_q <= HOST_LINK_CONTROL_RST;
         per_hi_q <= RESONANT_PERIOD_HIGH_RST;
         per_lo_q <= RESONANT_PERIOD_LOW_RST;
         nom_q <= NOMINAL_VOLTAGE_SETTING_RST;
         abs_q <= ABSOLUTE_VOLTAGE_SETTING_RST;
         cur_q <= CURRENT_RATING_SETTING_RST;
      end else if (wr_fire) begin
         unique case (ptr_q)
            // R11: only the mode and timeout bits are kept
            HOST_LINK_CONTROL_OFS: link_ctrl_q <= link_evt.data & HOST_LINK_CONTROL_MASK;
            RESONANT_PERIOD_HIGH_OFS: per_hi_q <= link_evt.data;
            // R11: bit 7 of the low part is dropped
            RESONANT_PERIOD_LOW_OFS: per_lo_q <= link_evt.data[6:0];
            NOMINAL_VOLTAGE_SETTING_OFS: nom_q <= link_evt.data;
            ABSOLUTE_VOLTAGE_SETTING_OFS: abs_q <= link_evt.data;
            // R9: five-bit current field
            CURRENT_RATING_SETTING_OFS: cur_q <= link_evt.data[4:0];
            // writes to other offsets are ignored
            default: cur_q <= cur_q;
         endcase
      end
   end

   // read byte for the pointer, refreshed every cycle; the link samples it only
   // a full byte slot after the pointer last moved, so it is settled by then
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rd_byte_q <= 8'h00;
      end else begin
         // R11: unused bits read as zero
         rd_byte_q <= rd_mux(ptr_q, link_ctrl_q, per_hi_q, per_lo_q, nom_q, abs_q, cur_q);
      end
   end

   // R4: high part weighs 128, which is plain concatenation
   // R5: the value is a period in 1333.32 ns steps, used as the starting drive frequency
   assign resonant_period_value = {per_hi_q, per_lo_q};
   // R9: current rating handed to the drive loop unchanged
   assign drive_current_rating = cur_q;

   // drive scaling; registered so the drive loop sees clean data
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         drive_full_scale <= NOMINAL_VOLTAGE_SETTING_RST;
         drive_level <= 8'h00;
         overdrive_level <= 8'h00;
      end else begin
         // R10: acceleration picks the full-scale setting
         if (accel_en) begin
            // R6: nominal voltage sets full scale
            drive_full_scale <= nom_q;
            drive_level <= scale(wave_level, nom_q);
         end else begin
            // R8: absolute maximum sets full scale
            drive_full_scale <= abs_q;
            drive_level <= scale(wave_level, abs_q);
         end
         // R7: with acceleration, overdrive never beyond the absolute maximum
         overdrive_level <= accel_en ? min8(overdrive_req, abs_q) : overdrive_req;
      end
   end

   // frame activity for the rest of the chip
   assign link_busy = busy_q;

endmodule

`default_nettype wire

// ==== rtl/hac_i2c_link.sv ====
// serial link slave clocked by the link clock; sends byte events to the register domain
`timescale 1ns/10ps
`default_nettype none

module hac_i2c_link
   import hac_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   input wire logic scl,
   input wire logic link_rst_n,
   input wire logic sda_i,
   input wire logic wr_mode_async,
   input wire logic [7:0] rd_byte,
   output logic sda_oe_n,
   output hac_evt_t evt_q,
   output logic evt_tgl_q
);

   logic [3:0] cnt_q;        // bit index in the 9-clock byte slot
   logic [6:0] sh_q;         // received bits
   logic ack_q;              // acknowledge this byte
   logic [7:0] tx_q;         // byte being sent on a read
   logic mode_s1_q;          // write mode synchroniser, first stage
   logic mode_s2_q;          // write mode synchroniser, second stage
   hac_phase_t phase_q;      // what the next byte means
   logic [7:0] rx_byte;      // byte completed on this edge

   assign rx_byte = {sh_q, sda_i};

   // write mode comes from the register domain, so it is synchronised here
   always_ff @(posedge scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
      end else begin
         mode_s1_q <= wr_mode_async;
         mode_s2_q <= mode_s1_q;
      end
   end

   // bit counter and shift register, sampled on the rising link edge
   always_ff @(posedge scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         cnt_q <= 4'h0;
         sh_q <= 7'h00;
      end else begin
         cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
         sh_q <= rx_byte[6:0];
      end
   end

   // byte decoding; an event toggles once per byte at most
   always_ff @(posedge scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         phase_q <= PH_ADDR;
         ack_q <= 1'b0;
         tx_q <= 8'h00;
         evt_q <= '{kind: EV_ADDR, data: 8'h00};
         evt_tgl_q <= 1'b0;
      end else if (cnt_q == 4'h7) begin
         unique case (phase_q)
            // slave address byte
            PH_ADDR: begin
               ack_q <= (rx_byte[7:1] == DEV_ADDR);
               if (rx_byte[7:1] != DEV_ADDR) begin
                  phase_q <= PH_IDLE;
               end else if (rx_byte[0]) begin
                  phase_q <= PH_READ;
               end else begin
                  phase_q <= PH_REG;
               end
            end
            // R1: one address then data
            PH_REG: begin
               ack_q <= 1'b1;
               evt_q <= '{kind: EV_ADDR, data: rx_byte};
               evt_tgl_q <= ~evt_tgl_q;
               phase_q <= PH_DATA;
            end
            // R2: repeat mode wants a new address
            PH_DATA: begin
               ack_q <= 1'b1;
               evt_q <= '{kind: EV_DATA, data: rx_byte};
               evt_tgl_q <= ~evt_tgl_q;
               if (mode_s2_q) begin
                  phase_q <= PH_REG;
               end
            end
            // master answers on reads; we stay off the line
            PH_READ, PH_IDLE: begin
               ack_q <= 1'b0;
            end
         endcase
      end else if (cnt_q == 4'h8 && phase_q == PH_READ) begin
         // a low acknowledge (ours after the address, or the master's) asks for a byte
         if (!sda_i) begin
            tx_q <= rd_byte;
            evt_q <= '{kind: EV_NEXT, data: 8'h00};
            evt_tgl_q <= ~evt_tgl_q;
         end else begin
            phase_q <= PH_IDLE;
         end
      end
   end

   // line driver changes on the falling edge, so data is stable while the clock is high
   always_ff @(negedge scl or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_oe_n <= 1'b1;
      end else if (cnt_q == 4'h8) begin
         sda_oe_n <= ~ack_q;
      end else if (phase_q == PH_READ) begin
         sda_oe_n <= tx_q[3'h7 - cnt_q[2:0]];
      end else begin
         sda_oe_n <= 1'b1;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/hac_pkg.sv ====
// shared constants, register map and carrier types of the haptic actuator configuration block
package hac_pkg;

   // system clock and bus idle timeout
   localparam int CLK_PERIOD_NS = 20;
   localparam int BUS_TIMEOUT_US = 35000;
   // longest time: integer division rounds down
   localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

   // scaling units of the actuator settings (for software and bench reference)
   localparam real PERIOD_UNIT_NS = 1333.32;
   localparam int PERIOD_RESET_HZ = 174;
   localparam int VOLT_STEP_UV = 23400;
   localparam int CUR_OFFSET_UA = 28600;
   localparam int CUR_STEP_UA = 7200;
   localparam int PERIOD_LOW_BITS = 7;

   // register offsets
   localparam logic [7:0] HOST_LINK_CONTROL_OFS = 8'h08;
   localparam logic [7:0] RESONANT_PERIOD_HIGH_OFS = 8'h0a;
   localparam logic [7:0] RESONANT_PERIOD_LOW_OFS = 8'h0b;
   localparam logic [7:0] NOMINAL_VOLTAGE_SETTING_OFS = 8'h0c;
   localparam logic [7:0] ABSOLUTE_VOLTAGE_SETTING_OFS = 8'h0d;
   localparam logic [7:0] CURRENT_RATING_SETTING_OFS = 8'h0e;

   // field positions in host_link_control
   localparam int WR_MODE_BIT = 7;
   localparam int BUS_IDLE_TIMEOUT_ENABLE_BIT = 6;
   localparam logic [7:0] HOST_LINK_CONTROL_MASK = 8'hc0;

   // reset values
   localparam logic [7:0] HOST_LINK_CONTROL_RST = 8'h40;
   localparam logic [7:0] RESONANT_PERIOD_HIGH_RST = 8'h21;
   localparam logic [6:0] RESONANT_PERIOD_LOW_RST = 7'h4f;
   localparam logic [7:0] NOMINAL_VOLTAGE_SETTING_RST = 8'h5a;
   localparam logic [7:0] ABSOLUTE_VOLTAGE_SETTING_RST = 8'h78;
   localparam logic [4:0] CURRENT_RATING_SETTING_RST = 5'h17;

   // slave address on the serial link; value is arbitrary
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4a;

   // kind of event passed from the link domain to the register domain
   typedef enum logic [1:0] {EV_ADDR, EV_DATA, EV_NEXT} hac_evt_kind_t;

   // one event word: kind plus the byte that came with it
   typedef struct packed {
      hac_evt_kind_t kind;
      logic [7:0] data;
   } hac_evt_t;

   // byte phase of the link slave
   typedef enum {PH_ADDR, PH_REG, PH_DATA, PH_READ, PH_IDLE} hac_phase_t;

endpackage
